// *** psc_pkg.sv ***
// Constants and carrier types of the process scheduler
package psc_pkg;
  // Empty list or empty channel marker
  localparam logic [31:0] NOT_PROC       = 32'h8000_0000;
  // Channel addresses in [BASE, TOP) belong to the serial links
  localparam logic [31:0] LINK_CHAN_BASE = 32'h8000_0000;
  localparam logic [31:0] LINK_CHAN_TOP  = 32'h8000_0020;
  // Workspace words below the workspace pointer
  localparam logic [31:0] WS_IPTR_OFS    = 32'h0000_0004;
  localparam logic [31:0] WS_LINK_OFS    = 32'h0000_0008;
  localparam logic [31:0] WS_MASK        = 32'hFFFF_FFFC;
  // Priority sits in bit 0 of a process descriptor
  localparam logic        PRI_HIGH       = 1'h0;
  localparam logic        PRI_LOW        = 1'h1;
  localparam int          SLICE_REF_CYCLES = 5120;
  localparam logic [1:0]  SLICE_MAX      = 2'h2;
  localparam int          CLK_MHZ        = 25;
  localparam int          SWITCH_MAX_NS  = 1000;
  localparam int          SWITCH_MAX_CYC = SWITCH_MAX_NS * CLK_MHZ / 1000;
  localparam int          WAKE_TYP_CYC   = 19;
  localparam int          WAKE_MAX_CYC   = 58;

  typedef enum logic [3:0] {
    OP_IN_MSG, OP_OUT_MSG, OP_OUT_BYTE, OP_OUT_WORD, OP_TALT_WAIT, OP_TIMER_IN,
    OP_STOP_ERR, OP_ALT_WAIT, OP_JUMP, OP_LOOP_END, OP_END_PROC, OP_STOP_PROC,
    OP_START_PROC
  } psc_op_type;

  typedef struct packed {
    logic        valid;
    psc_op_type  op;
    logic [31:0] iptr;
    logic [31:0] arg;
    logic [31:0] buf_ptr;
    logic [31:0] count;
  } psc_cmd_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] wptr;
  } psc_wake_type;

  typedef struct packed {
    logic        valid;
    logic        pri;
    logic [31:0] wptr;
    logic [31:0] iptr;
  } psc_run_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } psc_mem_type;

  typedef struct packed {
    logic        valid;
    logic        ext;
    logic        out_dir;
    logic [31:0] chan;
    logic [31:0] partner;
    logic [31:0] buf_ptr;
    logic [31:0] count;
  } psc_xfer_type;
endpackage

// *** psc_scheduler.sv ***
// Process scheduler: ready lists, timeslicing, join counting and channel setup
// Notes on behaviour
// - two ready lists, front and back each
// - waiting processes leave lists, get no cycles
// - low process descheduled after two slices
// - slice is 5120 reference clock cycles
// - switch only at descheduling point operations
// - save pointer in workspace, dispatch next
// - full process switch under one microsecond
// - start appends new workspace to list tail
// - ready processes always join the tail
// - end decrements join count, zero continues
// - low runs only with no high ready; a running low gets o_resched and runs on to its next jump, loop end or wait
// - high processes are never timesliced
// - low latency bounded by 2n-2 slices
// - high wake within 58 cycles of ready; code meets it only when no process runs
// - channels synchronised, first party waits
// - internal channel word, external serial link
// - channel address alone picks internal/external
// - partner waiting moves data, else deschedule
// - only listed operations are descheduling points
`timescale 1ns/1ps
`default_nettype none
module psc_scheduler #(
  parameter int SLICE_REF_EDGES = psc_pkg::SLICE_REF_CYCLES
) (
  input  wire logic                   i_clk,      // 25 MHz clock
  input  wire logic                   i_sys_rst,  // Synchronous reset
  input  wire logic                   i_ce,       // Clock enable
  input  wire logic                   i_ref_clk,  // 5 MHz reference input
  input  wire psc_pkg::psc_cmd_type   i_cmd,      // Operation from the core
  input  wire psc_pkg::psc_wake_type  i_wake,     // Link engine wakes a process
  input  wire logic [31:0]            i_mem_rdata,// Memory read data
  input  wire logic                   i_mem_ack,  // Memory access done
  output var  psc_pkg::psc_run_type   o_run,      // Running process
  output var  psc_pkg::psc_mem_type   o_mem,      // Memory request
  output var  psc_pkg::psc_xfer_type  o_xfer,     // Message transfer order
  output logic                        o_ready,    // Command may be issued
  output logic                        o_cmd_done, // Command done, caller goes on
  output logic                        o_wake_ack, // Wake request taken
  output logic                        o_resched   // Yield at next desched point
);
  typedef enum {
    ST_IDLE, ST_W_CRD, ST_W_CWR, ST_W_JRD, ST_W_JWR, ST_W_SAVE,
    ST_ENQ, ST_W_ENQ, ST_PICK, ST_W_LNK, ST_W_IP
  } psc_state_type;

  localparam int SW_CYC   = psc_pkg::SWITCH_MAX_CYC;
  localparam int WAKE_CYC = psc_pkg::WAKE_MAX_CYC;
  psc_state_type        state;
  logic [31:0]          lf [2];
  logic [31:0]          lb [2];
  psc_pkg::psc_cmd_type cmd_q;
  logic [31:0]          enq_w;
  logic [31:0]          pk;
  logic                 ev;
  logic                 dsp;
  logic                 is_cmd;
  logic                 partner;
  logic                 zero;
  logic                 enq_p;
  logic                 pick_p;
  logic                 disp_now;
  logic                 taken;
  logic                 ref_s1;
  logic                 ref_s2;
  logic                 ref_s3;
  logic [12:0]          ref_cnt;
  logic                 tick;
  logic [1:0]           slice_cnt;
  function automatic psc_pkg::psc_mem_type mreq(input logic we, input logic [31:0] a,
                                                input logic [31:0] d);
    mreq = '{req: 1'b1, we: we, addr: a, wdata: d};
  endfunction
  function automatic logic [31:0] ws(input logic [31:0] w, input logic [31:0] ofs);
    ws = (w & psc_pkg::WS_MASK) - ofs;
  endfunction
  function automatic logic is_ext(input logic [31:0] a);
    is_ext = (a >= psc_pkg::LINK_CHAN_BASE) && (a < psc_pkg::LINK_CHAN_TOP);
  endfunction

  assign enq_p    = enq_w[0];
  assign pick_p   = (lf[psc_pkg::PRI_HIGH] != psc_pkg::NOT_PROC) ? psc_pkg::PRI_HIGH : psc_pkg::PRI_LOW;
  assign disp_now = (state == ST_W_IP) && i_mem_ack;
  assign taken    = (state == ST_IDLE) && o_ready && i_cmd.valid;

  // Scheduling sequencer; memory answers arrive as i_mem_ack pulses
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state      <= ST_IDLE;
      lf         <= '{psc_pkg::NOT_PROC, psc_pkg::NOT_PROC};
      lb         <= '{psc_pkg::NOT_PROC, psc_pkg::NOT_PROC};
      cmd_q      <= '0;
      enq_w      <= '0;
      pk         <= '0;
      ev         <= 1'b0;
      dsp        <= 1'b0;
      is_cmd     <= 1'b0;
      partner    <= 1'b0;
      zero       <= 1'b0;
      o_run      <= '0;
      o_mem      <= '0;
      o_xfer     <= '0;
      o_ready    <= 1'b0;
      o_cmd_done <= 1'b0;
      o_wake_ack <= 1'b0;
    end else if (i_ce) begin
      o_mem.req    <= 1'b0;
      o_xfer.valid <= 1'b0;
      o_cmd_done   <= 1'b0;
      o_wake_ack   <= 1'b0;
      case (state)
        ST_IDLE: begin
          o_ready <= 1'b0;
          if (taken) begin
            cmd_q  <= i_cmd;
            is_cmd <= 1'b1;
            enq_w  <= o_run.wptr;
            ev     <= 1'b0;
            dsp    <= 1'b1;
            case (i_cmd.op)
              psc_pkg::OP_START_PROC: begin
                enq_w <= i_cmd.arg;
                dsp   <= 1'b0;
                state <= ST_ENQ;
              end
              psc_pkg::OP_IN_MSG, psc_pkg::OP_OUT_MSG, psc_pkg::OP_OUT_BYTE, psc_pkg::OP_OUT_WORD: begin
                if (is_ext(i_cmd.arg)) begin
                  // External channel: hand to the link and wait for its wake
                  o_xfer <= '{1'b1, 1'b1, i_cmd.op != psc_pkg::OP_IN_MSG, i_cmd.arg,
                              o_run.wptr, i_cmd.buf_ptr, i_cmd.count};
                  o_run.valid <= 1'b0;
                  o_mem <= mreq(1'b1, ws(o_run.wptr, psc_pkg::WS_IPTR_OFS), i_cmd.iptr);
                  state <= ST_W_SAVE;
                end else begin
                  o_mem <= mreq(1'b0, i_cmd.arg, '0);
                  state <= ST_W_CRD;
                end
              end
              psc_pkg::OP_JUMP, psc_pkg::OP_LOOP_END: begin
                if (o_resched) begin
                  ev          <= 1'b1;
                  o_run.valid <= 1'b0;
                  o_mem <= mreq(1'b1, ws(o_run.wptr, psc_pkg::WS_IPTR_OFS), i_cmd.iptr);
                  state <= ST_W_SAVE;
                end else begin
                  o_cmd_done <= 1'b1;
                end
              end
              psc_pkg::OP_END_PROC: begin
                o_mem <= mreq(1'b0, i_cmd.arg, '0);
                state <= ST_W_JRD;
              end
              default: begin
                // Timer and alternative waits, stops: off every list
                o_run.valid <= 1'b0;
                o_mem <= mreq(1'b1, ws(o_run.wptr, psc_pkg::WS_IPTR_OFS), i_cmd.iptr);
                state <= ST_W_SAVE;
              end
            endcase
          end else if (i_wake.valid) begin
            o_wake_ack <= 1'b1;
            is_cmd     <= 1'b0;
            enq_w      <= i_wake.wptr;
            dsp        <= 1'b0;
            state      <= ST_ENQ;
          end else if (!o_run.valid && lf[pick_p] != psc_pkg::NOT_PROC) begin
            state <= ST_PICK;
          end else begin
            o_ready <= 1'b1;
          end
        end
        ST_W_CRD: if (i_mem_ack) begin
          // First party leaves its descriptor in the word
          partner <= i_mem_rdata != psc_pkg::NOT_PROC;
          enq_w   <= i_mem_rdata;
          o_mem   <= mreq(1'b1, cmd_q.arg,
                          (i_mem_rdata == psc_pkg::NOT_PROC) ? o_run.wptr : psc_pkg::NOT_PROC);
          if (i_mem_rdata != psc_pkg::NOT_PROC) begin
            o_xfer <= '{1'b1, 1'b0, cmd_q.op != psc_pkg::OP_IN_MSG, cmd_q.arg,
                        i_mem_rdata, cmd_q.buf_ptr, cmd_q.count};
          end
          state <= ST_W_CWR;
        end
        ST_W_CWR: if (i_mem_ack) begin
          if (partner) begin
            dsp   <= 1'b0;
            state <= ST_ENQ;
          end else begin
            o_run.valid <= 1'b0;
            o_mem <= mreq(1'b1, ws(o_run.wptr, psc_pkg::WS_IPTR_OFS), cmd_q.iptr);
            state <= ST_W_SAVE;
          end
        end
        ST_W_JRD: if (i_mem_ack) begin
          o_mem <= mreq(1'b1, cmd_q.arg, i_mem_rdata - 32'h0000_0001);
          zero  <= i_mem_rdata == 32'h0000_0001;
          state <= ST_W_JWR;
        end
        ST_W_JWR: if (i_mem_ack) begin
          if (zero) begin
            o_cmd_done <= 1'b1;
            state      <= ST_IDLE;
          end else begin
            o_run.valid <= 1'b0;
            state       <= ST_PICK;
          end
        end
        ST_W_SAVE: if (i_mem_ack) begin
          state <= ev ? ST_ENQ : ST_PICK;
        end
        ST_ENQ: begin
          if (lf[enq_p] == psc_pkg::NOT_PROC) begin
            lf[enq_p] <= enq_w;
            lb[enq_p] <= enq_w;
            o_cmd_done <= is_cmd && !dsp;
            state <= dsp ? ST_PICK : ST_IDLE;
          end else begin
            o_mem <= mreq(1'b1, ws(lb[enq_p], psc_pkg::WS_LINK_OFS), enq_w);
            state <= ST_W_ENQ;
          end
        end
        ST_W_ENQ: if (i_mem_ack) begin
          lb[enq_p]  <= enq_w;
          o_cmd_done <= is_cmd && !dsp;
          state      <= dsp ? ST_PICK : ST_IDLE;
        end
        ST_PICK: begin
          // High list always drains first
          pk <= lf[pick_p];
          if (lf[pick_p] == psc_pkg::NOT_PROC) begin
            state <= ST_IDLE;
          end else if (lf[pick_p] == lb[pick_p]) begin
            lf[pick_p] <= psc_pkg::NOT_PROC;
            lb[pick_p] <= psc_pkg::NOT_PROC;
            o_mem <= mreq(1'b0, ws(lf[pick_p], psc_pkg::WS_IPTR_OFS), '0);
            state <= ST_W_IP;
          end else begin
            o_mem <= mreq(1'b0, ws(lf[pick_p], psc_pkg::WS_LINK_OFS), '0);
            state <= ST_W_LNK;
          end
        end
        ST_W_LNK: if (i_mem_ack) begin
          lf[pk[0]] <= i_mem_rdata;
          o_mem <= mreq(1'b0, ws(pk, psc_pkg::WS_IPTR_OFS), '0);
          state <= ST_W_IP;
        end
        ST_W_IP: if (i_mem_ack) begin
          o_run <= '{1'b1, pk[0], pk, i_mem_rdata};
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Reference clock is slow against i_clk, so its edges are sampled
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ref_s1  <= 1'b0;
      ref_s2  <= 1'b0;
      ref_s3  <= 1'b0;
      ref_cnt <= '0;
      tick    <= 1'b0;
    end else if (i_ce) begin
      ref_s1 <= i_ref_clk;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      tick   <= 1'b0;
      if (ref_s2 && !ref_s3) begin
        if (ref_cnt == 13'(SLICE_REF_EDGES - 1)) begin
          ref_cnt <= '0;
          tick    <= 1'b1;
        end else begin
          ref_cnt <= ref_cnt + 13'h0001;
        end
      end
    end
  end

  // Free-running ticks give a first slice of zero to one period
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      slice_cnt <= '0;
      o_resched <= 1'b0;
    end else if (i_ce) begin
      if (disp_now) begin
        slice_cnt <= '0;
        o_resched <= 1'b0;
      end else begin
        if (tick && o_run.valid && o_run.pri == psc_pkg::PRI_LOW && slice_cnt != psc_pkg::SLICE_MAX)
          slice_cnt <= slice_cnt + 2'h1;
        o_resched <= o_run.valid && o_run.pri == psc_pkg::PRI_LOW &&
                     (slice_cnt == psc_pkg::SLICE_MAX ||
                      lf[psc_pkg::PRI_HIGH] != psc_pkg::NOT_PROC);
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst || !i_ce);
  sequence s_low_running;
    o_run.valid && o_run.pri == psc_pkg::PRI_LOW && !disp_now;
  endsequence

  chk_slice_two: assert property (s_low_running ##0 slice_cnt == psc_pkg::SLICE_MAX |=> o_resched)
    else $error("low process not flagged after two slices");
  chk_high_waiting: assert property (s_low_running ##0 lf[psc_pkg::PRI_HIGH] != psc_pkg::NOT_PROC
                                     |=> o_resched)
    else $error("ready high process does not displace low one");
  chk_high_noslice: assert property (o_run.valid && o_run.pri == psc_pkg::PRI_HIGH &&
                                     $past(o_run.valid) && $past(o_run.pri) == psc_pkg::PRI_HIGH
                                     |-> !o_resched)
    else $error("high process was timesliced");
  chk_slice_reset: assert property (disp_now |=> slice_cnt == 2'h0 && o_run.valid)
    else $error("slice count not cleared on dispatch");
  chk_switch_time: assert property (state == ST_PICK && lf[pick_p] != psc_pkg::NOT_PROC
                                    |-> ##[1:SW_CYC] o_run.valid)
    else $error("process switch too slow");
  chk_wake_time: assert property (taken == 1'b0 && state == ST_IDLE && i_wake.valid && !o_run.valid &&
                                  i_wake.wptr[0] == psc_pkg::PRI_HIGH
                                  |-> ##[1:WAKE_CYC] o_run.valid)
    else $error("woken high process resumed late");
  chk_tail_link: assert property (state == ST_ENQ && lf[enq_p] != psc_pkg::NOT_PROC |=> o_mem.req && o_mem.we &&
                                  o_mem.addr == ws(lb[enq_p], psc_pkg::WS_LINK_OFS) && o_mem.wdata == enq_w)
    else $error("new process not linked behind list tail");
  chk_tail_update: assert property (state == ST_W_ENQ && i_mem_ack |=> lb[enq_p] == enq_w)
    else $error("back pointer not moved to new tail");
  chk_wait_save: assert property (taken && i_cmd.op == psc_pkg::OP_TIMER_IN |=> !o_run.valid && o_mem.we &&
                                  o_mem.wdata == $past(i_cmd.iptr))
    else $error("waiting process not descheduled with saved pointer");
  chk_ext_chan: assert property (taken && is_ext(i_cmd.arg) && (i_cmd.op inside {psc_pkg::OP_IN_MSG,
                                 psc_pkg::OP_OUT_MSG, psc_pkg::OP_OUT_BYTE, psc_pkg::OP_OUT_WORD})
                                 |=> o_xfer.valid && o_xfer.ext && !o_run.valid)
    else $error("external channel not handed to link");
endmodule
`default_nettype wire

// *** psc_partner.sv ***
// Memory and serial link engine model facing the scheduler
`timescale 1ns/1ps
`default_nettype none
module psc_partner #(
  parameter int LINK_DLY = 2
) (
  input  wire logic                  i_clk,      // Bench clock
  input  wire psc_pkg::psc_mem_type  i_mem,      // Memory request
  input  wire psc_pkg::psc_xfer_type i_xfer,     // Transfer order
  input  wire psc_pkg::psc_run_type  i_run,      // Running process
  input  wire logic                  i_wake_ack, // Wake taken
  output var  psc_pkg::psc_wake_type o_wake,     // Link wakes a process
  output logic [31:0]                o_rdata,    // Read data
  output logic                       o_ack       // Access done
);
  logic [31:0]          mem [logic [31:0]];
  logic [31:0]          last_wptr;
  logic [31:0]          wake_ptr;
  logic                 slow;
  logic                 pend;
  int                   link_cnt;
  psc_pkg::psc_mem_type held;
  initial begin
    o_wake = '0;
    o_rdata = '0;
    o_ack = 1'h0;
    slow = 1'h0;
    pend = 1'h0;
    link_cnt = 0;
    last_wptr = '0;
    held = '0;
  end
  // Latency alternates between one and two cycles
  always @(negedge i_clk) begin : serve
    psc_pkg::psc_mem_type r;
    r = i_mem.req ? i_mem : held;
    o_ack <= 1'h0;
    // Idle read bus shows inverted data, never a stale match
    o_rdata <= ~o_rdata;
    if ((i_mem.req && !slow) || pend) begin
      o_ack <= 1'h1;
      if (r.we) mem[r.addr] = r.wdata;
      o_rdata <= (!r.we && mem.exists(r.addr)) ? mem[r.addr] : ~r.addr;
    end
    if (i_mem.req) begin
      held <= i_mem;
      slow <= ~slow;
    end
    pend <= i_mem.req && slow;
  end
  always @(negedge i_clk) begin : link
    if (i_run.valid) last_wptr <= i_run.wptr;
    if (i_xfer.valid && i_xfer.ext) begin
      link_cnt <= LINK_DLY;
      wake_ptr <= i_run.valid ? i_run.wptr : last_wptr;
    end else if (link_cnt > 1) link_cnt <= link_cnt - 1;
    else if (link_cnt == 1) begin
      link_cnt <= 0;
      o_wake <= '{1'h1, wake_ptr};
    end
    if (o_wake.valid && i_wake_ack) o_wake <= '{1'h0, ~o_wake.wptr};
  end
endmodule
`default_nettype wire

// *** test_process_scheduler.sv ***
// Self-checking bench of the process scheduler
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module test_process_scheduler;
  localparam int          SLICE = 4;
  localparam logic [31:0] P1 = 32'h0000_1000, P2 = 32'h0000_2001, P3 = 32'h0000_3001;
  localparam logic [31:0] JC = 32'h0000_0500, CH = 32'h0000_0600, TOPC = psc_pkg::LINK_CHAN_TOP;
  logic                  clk, rst, ce, ref_clk, ref_en, wake_ack, mem_ack, resched, ready, done;
  logic                  seen_done, seen_xfer, run_q, wk_q;
  logic [31:0]           rdata, last_ip, cur, oth, ch;
  logic [31:0]           q [$];
  logic [15:0]           rnd;
  int                    errors, total_checks, cyc, wake_t, run_t, ref_cnt, n;
  psc_pkg::psc_cmd_type  cmd_r;
  psc_pkg::psc_wake_type wk;
  psc_pkg::psc_run_type  run;
  psc_pkg::psc_mem_type  mreq;
  psc_pkg::psc_xfer_type xfer, xf;
  psc_pkg::psc_op_type   ops [5];

  psc_scheduler #(.SLICE_REF_EDGES(SLICE)) psc_scheduler_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_ref_clk(ref_clk), .i_cmd(cmd_r), .i_wake(wk),
    .i_mem_rdata(rdata), .i_mem_ack(mem_ack), .o_run(run), .o_mem(mreq), .o_xfer(xfer),
    .o_ready(ready), .o_cmd_done(done), .o_wake_ack(wake_ack), .o_resched(resched));
  psc_partner psc_partner_inst (
    .i_clk(clk), .i_mem(mreq), .i_xfer(xfer), .i_run(run), .i_wake_ack(wake_ack),
    .o_wake(wk), .o_rdata(rdata), .o_ack(mem_ack));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] ip_addr(input logic [31:0] p);
    return (p & psc_pkg::WS_MASK) - psc_pkg::WS_IPTR_OFS;
  endfunction
  function automatic logic is_ext(input logic [31:0] c);
    return c >= psc_pkg::LINK_CHAN_BASE && c < psc_pkg::LINK_CHAN_TOP;
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Issues one command, then waits until a process runs and the port is free
  // Lists move only through such commands, never by direct writes
  task automatic cmd(input psc_pkg::psc_op_type op, input logic [31:0] a, input logic [31:0] b = 32'h0);
    for (n = 0; n < 100 && ready !== 1'h1; n++) @(negedge clk);
    if (n == 100) begin errors++; summarize(); end
    rnd = lfsr(rnd);
    last_ip = {14'h0, rnd, 2'h0};
    seen_done = 1'h0;
    seen_xfer = 1'h0;
    cmd_r = '{1'h1, op, last_ip, a, b, {16'h0, rnd}};
    @(negedge clk);
    cmd_r.valid = 1'h0;
    for (n = 0; n < 200 && !(ready === 1'h1 && run.valid === 1'h1); n++) @(negedge clk);
    if (n == 200) begin errors++; summarize(); end
    // A done pulse falls on or before the edge where ready rises; the posedge block has caught it
    seen_done = seen_done | (done === 1'h1);
  endtask

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Offset keeps reference edges away from bench clock edges
  initial begin
    ref_clk = 1'h0;
    #10;
    forever #100 if (ref_en) ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) ref_cnt++;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    run_q <= run.valid;
    wk_q <= wk.valid;
    if (done) seen_done <= 1'h1;
    if (xfer.valid) begin
      seen_xfer <= 1'h1;
      xf <= xfer;
    end
    if (wk.valid && !wk_q) wake_t <= cyc;
    if (run.valid && !run_q) run_t <= cyc;
  end

  initial begin
    rst = 1'h1;
    ce = 1'h1;
    ref_en = 1'h0;
    cmd_r = '0;
    rnd = 16'h0056;
    errors = 0;
    total_checks = 0;
    cyc = 0;
    ref_cnt = 0;
    ops = '{psc_pkg::OP_TALT_WAIT, psc_pkg::OP_TIMER_IN, psc_pkg::OP_STOP_ERR, psc_pkg::OP_ALT_WAIT,
            psc_pkg::OP_STOP_PROC};
    repeat (8) @(negedge clk);
    `CHK("reset outputs", 2'h0, ({run.valid, ready}))
    rst = 1'h0;
    psc_partner_inst.mem[ip_addr(P1)] = 32'h0000_0100;
    psc_partner_inst.mem[ip_addr(P2)] = 32'h0000_0200;
    psc_partner_inst.mem[ip_addr(P3)] = 32'h0000_0300;
    cmd(psc_pkg::OP_START_PROC, P1);
    `CHK("start run", ({1'h1, 1'h0, P1, 32'h0000_0100}), run)
    cmd(psc_pkg::OP_OUT_WORD, 32'h8000_0008);
    `CHK("ext out", 1'h1, xf.ext)
    `CHK("ip saved", last_ip, psc_partner_inst.mem[ip_addr(P1)])
    `CHK("resumed", ({1'h1, 1'h0, P1, last_ip}), run)
    `CHK("wake latency", 1'h1, (run_t - wake_t <= psc_pkg::WAKE_MAX_CYC))
    cmd(psc_pkg::OP_START_PROC, P2);
    cmd(psc_pkg::OP_START_PROC, P3);
    `CHK("high keeps running", ({1'h1, P1}), ({seen_done, run.wptr}))
    psc_partner_inst.mem[JC] = 32'h0000_0002;
    cmd(psc_pkg::OP_END_PROC, JC);
    `CHK("switch time", 1'h1, (n <= psc_pkg::SWITCH_MAX_CYC))
    `CHK("join count", 32'h0000_0001, psc_partner_inst.mem[JC])
    `CHK("low head", ({1'h1, 1'h1, P2, 32'h0000_0200}), run)
    psc_partner_inst.mem[CH] = psc_pkg::NOT_PROC;
    cmd(psc_pkg::OP_IN_MSG, CH);
    `CHK("chan holds waiter", P2, psc_partner_inst.mem[CH])
    `CHK("reader waits", ({1'h0, P3}), ({seen_xfer, run.wptr}))
    cmd(psc_pkg::OP_OUT_MSG, CH);
    `CHK("internal move", ({3'h5, P2}), ({seen_done, xf.ext, xf.out_dir, xf.partner}))
    `CHK("chan emptied", psc_pkg::NOT_PROC, psc_partner_inst.mem[CH])
    cmd(psc_pkg::OP_JUMP, 32'h0);
    `CHK("jump no switch", ({1'h1, P3}), ({seen_done, run.wptr}))
    ref_cnt = 0;
    ref_en = 1'h1;
    // Reference stops after the expected edge count, so a late flag times out
    for (n = 0; n < 400 && resched !== 1'h1; n++) begin
      if (ref_cnt == 2 * SLICE) ref_en = 1'h0;
      @(negedge clk);
    end
    if (n == 400) begin errors++; summarize(); end
    ref_en = 1'h0;
    `CHK("two slices", 2 * SLICE, ref_cnt)
    cmd(psc_pkg::OP_JUMP, 32'h0);
    `CHK("forced switch", ({P2, 1'h0}), ({run.wptr, resched}))
    cur = P2;
    oth = P3;
    repeat (6) begin
      rnd = lfsr(rnd);
      ch = psc_pkg::LINK_CHAN_BASE + {27'h0, rnd[4:2], 2'h0};
      cmd(psc_pkg::OP_OUT_BYTE, ch, {rnd, 16'h0});
      `CHK("link chan", ({is_ext(ch), 1'h1, ch}), ({xf.ext, xf.out_dir, xf.chan}))
      `CHK("link data", ({cmd_r.buf_ptr, cmd_r.count}), ({xf.buf_ptr, xf.count}))
      `CHK("next runs", oth, run.wptr)
      ch = cur;
      cur = oth;
      oth = ch;
    end
    psc_partner_inst.mem[TOPC] = psc_pkg::NOT_PROC;
    cmd(psc_pkg::OP_OUT_MSG, TOPC);
    `CHK("top is internal", ({1'h0, cur}), ({seen_xfer, psc_partner_inst.mem[TOPC]}))
    `CHK("waiter off list", oth, run.wptr)
    cmd(psc_pkg::OP_START_PROC, P1);
    `CHK("high ready yields", 1'h1, resched)
    cmd(psc_pkg::OP_LOOP_END, 32'h0);
    `CHK("high first", ({1'h1, 1'h0, P1}), ({run.valid, run.pri, run.wptr}))
    psc_partner_inst.mem[JC] = 32'h0000_0001;
    cmd(psc_pkg::OP_END_PROC, JC);
    `CHK("last joins", ({1'h1, P1, 32'h0}), ({seen_done, run.wptr, psc_partner_inst.mem[JC]}))
    q = {oth};
    for (int k = 0; k < 5; k++) begin
      ch = 32'h0000_4001 + 32'h0000_1000 * k;
      psc_partner_inst.mem[ip_addr(ch)] = 32'h0000_0400;
      q.push_back(ch);
      cmd(psc_pkg::OP_START_PROC, ch);
      cmd(ops[k], 32'h0);
      ch = q.pop_front();
      `CHK("fifo dispatch", ch, run.wptr)
    end
    ce = 1'h0;
    cur = run.wptr;
    cmd_r = '{1'h1, psc_pkg::OP_STOP_PROC, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (4) @(negedge clk);
    cmd_r.valid = 1'h0;
    `CHK("frozen", ({1'h1, cur}), ({run.valid, run.wptr}))
    ce = 1'h1;
    summarize();
  end
endmodule
`default_nettype wire
